// file: src/tram_monitor.sv
// alert evaluation, averaging, supply-good and sequencing check with APB registers
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// [R1] each shunt result above its channel critical limit pulls the critical pin low
// [R2] a per-channel critical flag is set to 1 in the status register
// [R3] selected shunt results are summed per cycle and checked against the sum limit
// [R4] each averaged shunt value above its warning limit pulls the warning pin low
// [R5] status shows which channel caused the warning
// [R6] supply good goes high only when all three bus voltages exceed the upper limit
// [R7] supply good goes low when any bus voltage is below lower limit; ranks second
// [R8] between the limits supply good keeps its previous state
// [R9] reset defaults the mode to continuous shunt and bus conversion
// [R10] the sequencing check waits for rail one at 1.2 V, then watches rail two
// [R11] rail two still below 1.2 V after four full cycles pulls the sequencing pin low
// [R12] a configuration write before the check ends turns the sequencing alert off
// [R13] once off it stays off until power-on or a software reset
// [R14] writing one to configuration bit 15 returns every register except supply good to its default
// [R15] software reset leaves supply good as it was until re-evaluated
// [R16] software reset restores the limit registers used by the supply good check
// [R17] the averager scales the difference of new sample and previous output
// [R18] the scaled difference plus previous output becomes the new average
// [R19] the done flag sets after a cycle; clears on configuration write or status read
// [R20] power-on loads every threshold register with its default
module tram_monitor (
    input wire logic SYS_CLK,
    input wire logic RESETN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic SAMPLE_VALID,
    input wire logic SAMPLE_BUS,
    input wire logic [1:0] SAMPLE_CH,
    input wire logic [15:0] SAMPLE_DATA,
    output logic [2:0] CONV_MODE,
    output logic CRIT_PULL_OE,
    output logic WARN_PULL_OE,
    output logic PV_PULL_OE,
    output logic TC_PULL_OE
);
    logic [15:0] cfg_reg;
    logic [15:0] crit_lim_reg [0:2];
    logic [15:0] warn_lim_reg [0:2];
    logic [15:0] sum_lim_reg;
    logic [3:0] sum_ctrl_reg;
    logic [15:0] pv_hi_reg;
    logic [15:0] pv_lo_reg;
    logic [15:0] bus_reg [0:2];
    logic [2:0] crit_flag_reg;
    logic [2:0] warn_flag_reg;
    logic sum_flag_reg;
    logic done_flag_reg;
    logic pv_reg;
    logic srst_reg;
    logic cyc_d_reg;
    logic signed [17:0] acc_reg;
    tram_pkg::tram_tc_e tc_reg;
    logic [2:0] tc_cnt_reg;

    // bus decode; zero wait states so every access phase completes
    wire setup_ph = PSEL & ~PENABLE;
    wire wr_acc = PSEL & PENABLE & PWRITE;
    wire rd_acc = PSEL & PENABLE & ~PWRITE;
    wire cfg_wr = wr_acc & (PADDR == tram_pkg::OFS_CONFIG);
    wire soft_rst = cfg_wr & PWDATA[tram_pkg::CFG_RST_BIT];
    wire st_rd = rd_acc & (PADDR == tram_pkg::OFS_STATUS);

    function automatic logic is_ofs(input logic [7:0] a, input logic [7:0] base, input int idx);
        is_ofs = (a == 8'(base + 8'(idx * 4)));
    endfunction : is_ofs

    // sample decode
    wire ch_ok = SAMPLE_CH != 2'h3;
    wire shunt_v = SAMPLE_VALID & ~SAMPLE_BUS & ch_ok;
    wire bus_v = SAMPLE_VALID & SAMPLE_BUS & ch_ok;
    wire cycle_end = bus_v & (SAMPLE_CH == 2'h2);
    wire signed [15:0] samp_s = $signed(SAMPLE_DATA);

    logic [2:0] crit_hit;
    logic [2:0] warn_hit;
    logic [2:0] above_hi;
    logic [2:0] below_lo;
    logic [15:0] bus_now [0:2];
    wire avg_v;
    wire [1:0] avg_ch;
    wire [15:0] avg_val;
    wire [47:0] all_avg;

    always_comb begin
        for (int i = 0; i < 3; i++) begin
            crit_hit[i] = shunt_v & (SAMPLE_CH == 2'(i)) & (samp_s > $signed(crit_lim_reg[i])); // [R1]
            warn_hit[i] = avg_v & (avg_ch == 2'(i)) & ($signed(avg_val) > $signed(warn_lim_reg[i])); // [R4]
            bus_now[i] = (bus_v && SAMPLE_CH == 2'(i)) ? SAMPLE_DATA : bus_reg[i];
            above_hi[i] = bus_now[i] > pv_hi_reg;
            below_lo[i] = bus_now[i] < pv_lo_reg;
        end
    end

    // summation over the channels selected in sum control [2:0]; [3] enables
    wire sum_add = shunt_v & sum_ctrl_reg[SAMPLE_CH];
    wire signed [17:0] acc_upd = sum_add ? 18'(acc_reg + 18'(samp_s)) : acc_reg;
    wire sum_hit = cycle_end & sum_ctrl_reg[3] & (acc_upd > 18'($signed(sum_lim_reg))); // [R3]

    wire [2:0] crit_next = (crit_flag_reg & ~{3{st_rd}}) | crit_hit; // [R2]
    wire [2:0] warn_next = (warn_flag_reg & ~{3{st_rd}}) | warn_hit; // [R5]
    wire sum_next = (sum_flag_reg & ~st_rd) | sum_hit;
    // set wins over clear for the done flag
    wire done_next = (done_flag_reg & ~(st_rd | cfg_wr)) | cyc_d_reg; // [R19]

    // supply good: all-above outranks any-below; otherwise hold
    wire pv_next = (cycle_end & (&above_hi)) ? 1'b1 : // [R6]
                   (cycle_end & (|below_lo)) ? 1'b0 : pv_reg; // [R7] [R8]

    // sequencing check
    wire rail_one_up = bus_v & (SAMPLE_CH == 2'h0) & (SAMPLE_DATA >= tram_pkg::TC_THRESH_CODE);
    wire rail_two_up = bus_v & (SAMPLE_CH == 2'h1) & (SAMPLE_DATA >= tram_pkg::TC_THRESH_CODE);
    tram_pkg::tram_tc_e tc_next;
    logic [2:0] tc_cnt_next;

    always_comb begin
        tc_next = tc_reg;
        tc_cnt_next = tc_cnt_reg;
        case (tc_reg)
            tram_pkg::TC_WAIT_ONE: begin
                if (cfg_wr) tc_next = tram_pkg::TC_OFF; // [R12]
                else if (rail_one_up) begin
                    tc_next = tram_pkg::TC_WAIT_TWO; // [R10]
                    tc_cnt_next = 3'h0;
                end
            end
            tram_pkg::TC_WAIT_TWO: begin
                if (cfg_wr) tc_next = tram_pkg::TC_OFF; // [R12]
                else if (rail_two_up) tc_next = tram_pkg::TC_PASS; // [R10]
                else if (cycle_end) begin
                    tc_cnt_next = 3'(tc_cnt_reg + 3'h1);
                    if (tc_cnt_next == tram_pkg::TC_CYCLES) tc_next = tram_pkg::TC_FAIL; // [R11]
                end
            end
            tram_pkg::TC_PASS: tc_next = tram_pkg::TC_PASS;
            tram_pkg::TC_FAIL: tc_next = tram_pkg::TC_FAIL;
            tram_pkg::TC_OFF: tc_next = tram_pkg::TC_OFF; // [R13]
            default: tc_next = tram_pkg::TC_WAIT_ONE;
        endcase
    end

    // read mux; status read has its side effect in the access phase
    logic [31:0] rd_next;
    logic err_next;
    always_comb begin
        rd_next = 32'h0000_0000;
        err_next = 1'b0;
        if (PADDR == tram_pkg::OFS_CONFIG) rd_next = {16'h0000, 1'b0, cfg_reg[14:0]};
        else if (PADDR == tram_pkg::OFS_SUM_LIM) rd_next = {16'h0000, sum_lim_reg};
        else if (PADDR == tram_pkg::OFS_SUM_CTRL) rd_next = {28'h0000000, sum_ctrl_reg};
        else if (PADDR == tram_pkg::OFS_PV_UPPER) rd_next = {16'h0000, pv_hi_reg};
        else if (PADDR == tram_pkg::OFS_PV_LOWER) rd_next = {16'h0000, pv_lo_reg};
        else if (PADDR == tram_pkg::OFS_STATUS) begin
            rd_next = {22'h000000, done_flag_reg, (tc_reg == tram_pkg::TC_FAIL), pv_reg,
                       sum_flag_reg, warn_flag_reg, crit_flag_reg};
        end else begin
            err_next = 1'b1;
            for (int i = 0; i < 3; i++) begin
                if (is_ofs(PADDR, tram_pkg::OFS_CRIT_LIM0, i)) begin
                    rd_next = {16'h0000, crit_lim_reg[i]};
                    err_next = 1'b0;
                end
                if (is_ofs(PADDR, tram_pkg::OFS_WARN_LIM0, i)) begin
                    rd_next = {16'h0000, warn_lim_reg[i]};
                    err_next = 1'b0;
                end
                if (is_ofs(PADDR, tram_pkg::OFS_AVG0, i)) begin
                    rd_next = {16'h0000, all_avg[i*16 +: 16]};
                    err_next = 1'b0;
                end
            end
        end
    end

    tram_averager u_avg (
        .clk(SYS_CLK),
        .rst_n(RESETN),
        .srst(srst_reg),
        .in_valid(shunt_v),
        .in_ch(SAMPLE_CH),
        .in_data(SAMPLE_DATA),
        .factor(cfg_reg[tram_pkg::CFG_AVG_LSB +: 3]),
        .out_valid(avg_v),
        .out_ch(avg_ch),
        .out_avg(avg_val),
        .all_avg(all_avg)
    );

    // registers and flags; soft reset reaches all but supply good
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin // [R20]
            cfg_reg <= {4'h0, tram_pkg::AVG_RST, 6'h00, tram_pkg::MODE_CONT_BOTH}; // [R9]
            for (int i = 0; i < 3; i++) begin
                crit_lim_reg[i] <= tram_pkg::CRIT_LIM_RST;
                warn_lim_reg[i] <= tram_pkg::WARN_LIM_RST;
                bus_reg[i] <= 16'h0000;
            end
            sum_lim_reg <= tram_pkg::SUM_LIM_RST;
            sum_ctrl_reg <= tram_pkg::SUM_CTRL_RST;
            pv_hi_reg <= tram_pkg::PV_UPPER_RST;
            pv_lo_reg <= tram_pkg::PV_LOWER_RST;
            crit_flag_reg <= 3'h0;
            warn_flag_reg <= 3'h0;
            sum_flag_reg <= 1'b0;
            done_flag_reg <= 1'b0;
            cyc_d_reg <= 1'b0;
            acc_reg <= '0;
            tc_reg <= tram_pkg::TC_WAIT_ONE; // [R13]
            tc_cnt_reg <= 3'h0;
        end else if (srst_reg) begin // [R14] [R16]
            cfg_reg <= {4'h0, tram_pkg::AVG_RST, 6'h00, tram_pkg::MODE_CONT_BOTH}; // [R9]
            for (int i = 0; i < 3; i++) begin
                crit_lim_reg[i] <= tram_pkg::CRIT_LIM_RST;
                warn_lim_reg[i] <= tram_pkg::WARN_LIM_RST;
                bus_reg[i] <= 16'h0000;
            end
            sum_lim_reg <= tram_pkg::SUM_LIM_RST;
            sum_ctrl_reg <= tram_pkg::SUM_CTRL_RST;
            pv_hi_reg <= tram_pkg::PV_UPPER_RST;
            pv_lo_reg <= tram_pkg::PV_LOWER_RST;
            crit_flag_reg <= 3'h0;
            warn_flag_reg <= 3'h0;
            sum_flag_reg <= 1'b0;
            done_flag_reg <= 1'b0;
            cyc_d_reg <= 1'b0;
            acc_reg <= '0;
            tc_reg <= tram_pkg::TC_WAIT_ONE; // [R13]
            tc_cnt_reg <= 3'h0;
        end else begin
            if (cfg_wr) cfg_reg <= {1'b0, PWDATA[14:0]};
            for (int i = 0; i < 3; i++) begin
                if (wr_acc && is_ofs(PADDR, tram_pkg::OFS_CRIT_LIM0, i)) crit_lim_reg[i] <= PWDATA[15:0];
                if (wr_acc && is_ofs(PADDR, tram_pkg::OFS_WARN_LIM0, i)) warn_lim_reg[i] <= PWDATA[15:0];
                if (bus_v && SAMPLE_CH == 2'(i)) bus_reg[i] <= SAMPLE_DATA;
            end
            if (wr_acc && PADDR == tram_pkg::OFS_SUM_LIM) sum_lim_reg <= PWDATA[15:0];
            if (wr_acc && PADDR == tram_pkg::OFS_SUM_CTRL) sum_ctrl_reg <= PWDATA[3:0];
            if (wr_acc && PADDR == tram_pkg::OFS_PV_UPPER) pv_hi_reg <= PWDATA[15:0];
            if (wr_acc && PADDR == tram_pkg::OFS_PV_LOWER) pv_lo_reg <= PWDATA[15:0];
            crit_flag_reg <= crit_next;
            warn_flag_reg <= warn_next;
            sum_flag_reg <= sum_next;
            done_flag_reg <= done_next;
            cyc_d_reg <= cycle_end;
            acc_reg <= cycle_end ? 18'h00000 : acc_upd;
            tc_reg <= tc_next;
            tc_cnt_reg <= tc_cnt_next;
        end
    end

    // supply good survives the soft reset
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            pv_reg <= 1'b0;
            srst_reg <= 1'b0;
        end else begin
            pv_reg <= pv_next; // [R15]
            srst_reg <= soft_rst; // [R14]
        end
    end

    // pins and bus outputs, all from flip-flops
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            PRDATA <= 32'h0000_0000;
            PSLVERR <= 1'b0;
            PREADY <= 1'b0;
            CONV_MODE <= tram_pkg::MODE_CONT_BOTH;
            CRIT_PULL_OE <= 1'b0;
            WARN_PULL_OE <= 1'b0;
            PV_PULL_OE <= 1'b1;
            TC_PULL_OE <= 1'b0;
        end else begin
            PREADY <= 1'b1;
            if (setup_ph) begin
                PRDATA <= PWRITE ? 32'h0000_0000 : rd_next;
                PSLVERR <= err_next;
            end
            CONV_MODE <= srst_reg ? tram_pkg::MODE_CONT_BOTH : (cfg_wr ? PWDATA[2:0] : cfg_reg[2:0]);
            CRIT_PULL_OE <= ~srst_reg & ((|crit_next) | sum_next); // [R1] [R3]
            WARN_PULL_OE <= ~srst_reg & (|warn_next); // [R4]
            PV_PULL_OE <= ~pv_next; // [R6] [R7]
            TC_PULL_OE <= ~srst_reg & (tc_next == tram_pkg::TC_FAIL); // [R11]
        end
    end

    crit_pin_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN) // [R1]
        (|crit_hit && !srst_reg) |=> CRIT_PULL_OE)
        else $error("critical pin not pulled after limit exceeded");
    crit_flag_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN) // [R2]
        (crit_hit[0] && !srst_reg) |=> crit_flag_reg[0])
        else $error("critical flag of rail one not set");
    sum_alert_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN) // [R3]
        (sum_hit && !srst_reg) |=> sum_flag_reg && CRIT_PULL_OE)
        else $error("sum limit breach not reported");
    warn_pin_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN) // [R4]
        (|warn_hit && !srst_reg) |=> WARN_PULL_OE && (warn_flag_reg != 3'h0))
        else $error("warning not raised");
    pv_rise_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN) // [R6]
        $rose(pv_reg) |-> $past(cycle_end) && $past(&above_hi))
        else $error("supply good rose without all rails above upper limit");
    pv_fall_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN) // [R7]
        (cycle_end && |below_lo && !(&above_hi)) |=> !pv_reg && PV_PULL_OE)
        else $error("supply good did not fall");
    pv_hold_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN) // [R8]
        !cycle_end |=> $stable(pv_reg))
        else $error("supply good changed outside evaluation");
    tc_off_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN) // [R12]
        (cfg_wr && !srst_reg && (tc_reg == tram_pkg::TC_WAIT_ONE || tc_reg == tram_pkg::TC_WAIT_TWO))
        |=> tc_reg == tram_pkg::TC_OFF)
        else $error("sequencing alert not disabled by configuration write");
    tc_fail_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN) // [R11]
        (tc_reg == tram_pkg::TC_FAIL && !srst_reg) |=> TC_PULL_OE)
        else $error("sequencing pin not pulled in fail state");
    srst_lim_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN) // [R16]
        srst_reg |=> pv_hi_reg == tram_pkg::PV_UPPER_RST && pv_lo_reg == tram_pkg::PV_LOWER_RST)
        else $error("limits not restored by software reset");
    done_set_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN) // [R19]
        (cycle_end && !srst_reg && !soft_rst) |-> ##2 done_flag_reg)
        else $error("done flag not set after cycle");
endmodule : tram_monitor
`default_nettype wire

// file: src/tram_pkg.sv
// shared constants and types of the three rail alert monitor
package tram_pkg;
    localparam int DATA_W = 16;
    localparam int SUM_W = 18;
    localparam int NCH = 3;

    // register byte offsets
    localparam logic [7:0] OFS_CONFIG = 8'h00;
    localparam logic [7:0] OFS_CRIT_LIM0 = 8'h04;
    localparam logic [7:0] OFS_WARN_LIM0 = 8'h10;
    localparam logic [7:0] OFS_SUM_LIM = 8'h1C;
    localparam logic [7:0] OFS_SUM_CTRL = 8'h20;
    localparam logic [7:0] OFS_PV_UPPER = 8'h24;
    localparam logic [7:0] OFS_PV_LOWER = 8'h28;
    localparam logic [7:0] OFS_STATUS = 8'h2C;
    localparam logic [7:0] OFS_AVG0 = 8'h30;

    // configuration fields
    localparam int CFG_RST_BIT = 15;
    localparam int CFG_AVG_LSB = 9;
    localparam int CFG_MODE_LSB = 0;

    // status fields
    localparam int ST_CRIT_LSB = 0;
    localparam int ST_WARN_LSB = 3;
    localparam int ST_SUM_BIT = 6;
    localparam int ST_PV_BIT = 7;
    localparam int ST_TC_BIT = 8;
    localparam int ST_DONE_BIT = 9;

    // values after reset
    localparam logic [2:0] MODE_CONT_BOTH = 3'h7;
    localparam logic [2:0] AVG_RST = 3'h0;
    localparam logic [15:0] CRIT_LIM_RST = 16'h7FFF;
    localparam logic [15:0] WARN_LIM_RST = 16'h7FFF;
    localparam logic [15:0] SUM_LIM_RST = 16'h7FFF;
    localparam logic [3:0] SUM_CTRL_RST = 4'h0;
    localparam logic [15:0] PV_UPPER_RST = 16'h0100;
    localparam logic [15:0] PV_LOWER_RST = 16'h0080;

    // sequencing check: 1.2 V in bus codes of 8 mV
    localparam int TC_THRESH_MV = 1200;
    localparam int BUS_LSB_UV = 8000;
    localparam logic [15:0] TC_THRESH_CODE = 16'((TC_THRESH_MV * 1000) / BUS_LSB_UV);
    localparam logic [2:0] TC_CYCLES = 3'h4;

    typedef enum logic [2:0] {TC_WAIT_ONE, TC_WAIT_TWO, TC_PASS, TC_FAIL, TC_OFF} tram_tc_e;

    // divide factor of the averaging field as a right shift
    function automatic logic [3:0] avg_shift(input logic [2:0] f);
        case (f)
            3'h0: avg_shift = 4'h0;
            3'h1: avg_shift = 4'h2;
            3'h2: avg_shift = 4'h4;
            3'h3: avg_shift = 4'h6;
            3'h4: avg_shift = 4'h7;
            3'h5: avg_shift = 4'h8;
            3'h6: avg_shift = 4'h9;
            default: avg_shift = 4'hA;
        endcase
    endfunction : avg_shift
endpackage : tram_pkg

// file: src/tram_averager.sv
// recursive averaging filter, one stored average per channel
`timescale 1ns/1ps
`default_nettype none
module tram_averager (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic srst,
    input wire logic in_valid,
    input wire logic [1:0] in_ch,
    input wire logic [15:0] in_data,
    input wire logic [2:0] factor,
    output logic out_valid,
    output logic [1:0] out_ch,
    output logic [15:0] out_avg,
    output logic [47:0] all_avg
);
    logic signed [15:0] avg_reg [0:2];
    logic signed [17:0] diff;
    logic signed [17:0] step;
    logic signed [17:0] sum;
    logic [15:0] avg_next;

    assign diff = 18'($signed(in_data)) - 18'(avg_reg[in_ch]);
    // arithmetic shift keeps negative steps from rounding toward the top
    assign step = diff >>> tram_pkg::avg_shift(factor);
    assign sum = 18'(avg_reg[in_ch]) + step;
    assign avg_next = sum[15:0];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 3; i++) avg_reg[i] <= '0;
            out_valid <= 1'b0;
            out_ch <= 2'h0;
            out_avg <= 16'h0000;
        end else if (srst) begin
            for (int i = 0; i < 3; i++) avg_reg[i] <= '0;
            out_valid <= 1'b0;
            out_ch <= 2'h0;
            out_avg <= 16'h0000;
        end else begin
            out_valid <= in_valid;
            if (in_valid) begin
                avg_reg[in_ch] <= avg_next; // [R17] [R18]
                out_ch <= in_ch;
                out_avg <= avg_next;
            end
        end
    end

    assign all_avg = {avg_reg[2], avg_reg[1], avg_reg[0]};
endmodule : tram_averager
`default_nettype wire

// file: verif/tram_power_ctrl.sv
// system power controller model watching the open-drain alert pins
`timescale 1ns/1ps
`default_nettype none
module tram_power_ctrl (
    input wire logic crit_oe,
    input wire logic warn_oe,
    input wire logic pv_oe,
    input wire logic tc_oe,
    output logic crit_pin,
    output logic warn_pin,
    output logic pv_pin,
    output logic tc_pin
);
    // released pins float to the pull-up level, never hold a stale value
    assign crit_pin = crit_oe ? 1'b0 : 1'b1;
    assign warn_pin = warn_oe ? 1'b0 : 1'b1;
    assign pv_pin = pv_oe ? 1'b0 : 1'b1;
    assign tc_pin = tc_oe ? 1'b0 : 1'b1;
endmodule : tram_power_ctrl
`default_nettype wire

// file: verif/test_three_rail_alert_monitor.sv
// self-checking bench of the three rail alert monitor
`timescale 1ns/1ps
`default_nettype none
module test_three_rail_alert_monitor;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, slverr;
    logic sv = 1'b0, sb = 1'b0;
    logic [1:0] sch = 2'h0;
    logic [15:0] sdat = 16'h0;
    logic [2:0] conv_mode;
    logic crit_oe, warn_oe, pv_oe, tc_oe, crit_pin, warn_pin, pv_pin, tc_pin;
    int err_total = 0;
    int checks_done = 0;
    int cycles = 0;

    tram_monitor DUT (.SYS_CLK(sys_clk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .SAMPLE_VALID(sv), .SAMPLE_BUS(sb), .SAMPLE_CH(sch), .SAMPLE_DATA(sdat), .CONV_MODE(conv_mode),
        .CRIT_PULL_OE(crit_oe), .WARN_PULL_OE(warn_oe), .PV_PULL_OE(pv_oe), .TC_PULL_OE(tc_oe));
    tram_power_ctrl ctrl (.crit_oe(crit_oe), .warn_oe(warn_oe), .pv_oe(pv_oe), .tc_oe(tc_oe),
        .crit_pin(crit_pin), .warn_pin(warn_pin), .pv_pin(pv_pin), .tc_pin(tc_pin));

    always #5 sys_clk = ~sys_clk;

    // whole run needs about 570 cycles
    always @(posedge sys_clk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            err_total = err_total + 1;
            finish_test();
        end
    end

    task finish_test;
        if (err_total == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : finish_test

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp) begin
            err_total = err_total + 1;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // no wait count assumed: poll pready at each access edge
    task apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        // only the bench timeout ends a stalled access
        while (pready !== 1'b1) @(posedge sys_clk);
        rd = prdata;
        slverr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task rchk(input logic [7:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 32'h0);
        chk(rd, exp);
    endtask : rchk

    task idle(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : idle

    task smp(input logic bus, input logic [1:0] ch, input logic [15:0] d);
        @(posedge sys_clk);
        sv <= 1'b1;
        sb <= bus;
        sch <= ch;
        sdat <= d;
        @(posedge sys_clk);
        sv <= 1'b0;
    endtask : smp

    // one full measurement cycle in the expected order, ends on rail three bus
    task cyc(input logic [15:0] s, input logic [15:0] b0, input logic [15:0] b1, input logic [15:0] b2);
        smp(1'b0, 2'h0, s);
        smp(1'b1, 2'h0, b0);
        smp(1'b0, 2'h1, s);
        smp(1'b1, 2'h1, b1);
        smp(1'b0, 2'h2, s);
        smp(1'b1, 2'h2, b2);
        idle(3);
    endtask : cyc

    // two spare cycles: a write landing in the reset pulse is lost
    task soft_rst;
        apb(1'b1, tram_pkg::OFS_CONFIG, 32'h0000_8000);
        idle(2);
    endtask : soft_rst

    task t_reset;
        chk(32'(pready), 32'h0);
        chk(32'(conv_mode), 32'h7);
        rchk(tram_pkg::OFS_CRIT_LIM0, 32'h7FFF);
        chk(32'(pready), 32'h1);
        rchk(tram_pkg::OFS_WARN_LIM0, 32'h7FFF);
        rchk(tram_pkg::OFS_SUM_LIM, 32'h7FFF);
        rchk(tram_pkg::OFS_PV_UPPER, 32'h0100);
        rchk(tram_pkg::OFS_PV_LOWER, 32'h0080);
        rchk(8'h40, 32'h0);
        chk(32'(slverr), 32'h1);
    endtask : t_reset

    // the cycle that sees rail one counts as the first of four
    task t_tc;
        repeat (5) cyc(16'h0, 16'h0, 16'h0, 16'h0);
        chk(32'(tc_oe), 32'h0);
        repeat (3) cyc(16'h0, 16'h00C8, 16'h0, 16'h0);
        chk(32'(tc_oe), 32'h0);
        cyc(16'h0, 16'h00C8, 16'h0, 16'h0);
        chk(32'(tc_pin), 32'h0);
        soft_rst();
        chk(32'(tc_oe), 32'h0);
        apb(1'b1, tram_pkg::OFS_CONFIG, 32'h7);
        repeat (5) cyc(16'h0, 16'h00C8, 16'h0, 16'h0);
        chk(32'(tc_oe), 32'h0);
        soft_rst();
        repeat (5) cyc(16'h0, 16'h00C8, 16'h0, 16'h0);
        chk(32'(tc_oe), 32'h1);
        soft_rst();
    endtask : t_tc

    task t_pv;
        cyc(16'h0, 16'h0200, 16'h0200, 16'h0200);
        chk(32'(pv_pin), 32'h1);
        cyc(16'h0, 16'h0200, 16'h0090, 16'h0200);
        chk(32'(pv_oe), 32'h0);
        cyc(16'h0, 16'h0040, 16'h0200, 16'h0200);
        chk(32'(pv_oe), 32'h1);
        cyc(16'h0, 16'h0090, 16'h0200, 16'h0200);
        chk(32'(pv_oe), 32'h1);
        apb(1'b0, tram_pkg::OFS_STATUS, 32'h0);
        chk(rd & 32'h200, 32'h200);
        rchk(tram_pkg::OFS_STATUS, 32'h0);
        cyc(16'h0, 16'h0090, 16'h0200, 16'h0200);
        apb(1'b1, tram_pkg::OFS_CONFIG, 32'h7);
        rchk(tram_pkg::OFS_STATUS, 32'h0);
        apb(1'b1, tram_pkg::OFS_PV_UPPER, 32'h0300);
        cyc(16'h0, 16'h0200, 16'h0200, 16'h0200);
        chk(32'(pv_oe), 32'h1);
        soft_rst();
        chk(32'(pv_oe), 32'h1);
        rchk(tram_pkg::OFS_PV_UPPER, 32'h0100);
        cyc(16'h0, 16'h0200, 16'h0200, 16'h0200);
        chk(32'(pv_oe), 32'h0);
        soft_rst();
        chk(32'(pv_oe), 32'h0);
    endtask : t_pv

    task t_crit;
        apb(1'b1, tram_pkg::OFS_CRIT_LIM0 + 8'h04, 32'h0080);
        smp(1'b0, 2'h1, 16'h0080);
        smp(1'b0, 2'h3, 16'h0100);
        idle(2);
        chk(32'(crit_oe), 32'h0);
        smp(1'b0, 2'h1, 16'h0081);
        idle(2);
        chk(32'(crit_pin), 32'h0);
        apb(1'b0, tram_pkg::OFS_STATUS, 32'h0);
        chk(rd & 32'h7, 32'h2);
        apb(1'b1, tram_pkg::OFS_CONFIG, 32'h0);
        // mode output takes the written value on the same edge as the write lands
        idle(1);
        chk(32'(conv_mode), 32'h0);
        soft_rst();
        chk(32'(conv_mode), 32'h7);
        chk(32'(crit_oe), 32'h0);
        rchk(tram_pkg::OFS_CRIT_LIM0 + 8'h04, 32'h7FFF);
    endtask : t_crit

    task t_sum;
        apb(1'b1, tram_pkg::OFS_SUM_LIM, 32'h0100);
        apb(1'b1, tram_pkg::OFS_SUM_CTRL, 32'hB);
        cyc(16'h0060, 16'h0200, 16'h0200, 16'h0200);
        chk(32'(crit_oe), 32'h0);
        apb(1'b1, tram_pkg::OFS_SUM_CTRL, 32'hF);
        cyc(16'h0060, 16'h0200, 16'h0200, 16'h0200);
        chk(32'(crit_oe), 32'h1);
        apb(1'b0, tram_pkg::OFS_STATUS, 32'h0);
        chk(rd & 32'h47, 32'h40);
    endtask : t_sum

    task t_avg;
        soft_rst();
        apb(1'b1, tram_pkg::OFS_WARN_LIM0, 32'h0050);
        smp(1'b0, 2'h0, 16'h0060);
        idle(3);
        chk(32'(warn_pin), 32'h0);
        rchk(tram_pkg::OFS_AVG0, 32'h0060);
        apb(1'b0, tram_pkg::OFS_STATUS, 32'h0);
        chk(rd & 32'h38, 32'h08);
        apb(1'b1, tram_pkg::OFS_CONFIG, 32'h0207);
        smp(1'b0, 2'h0, 16'h00A0);
        idle(3);
        rchk(tram_pkg::OFS_AVG0, 32'h0070);
        apb(1'b1, tram_pkg::OFS_CONFIG, 32'h0E07);
        smp(1'b0, 2'h0, 16'h0470);
        idle(3);
        rchk(tram_pkg::OFS_AVG0, 32'h0071);
    endtask : t_avg

    initial begin
        repeat (6) @(posedge sys_clk);
        resetn <= 1'b1;
        t_reset();
        t_tc();
        t_pv();
        t_crit();
        t_sum();
        t_avg();
        finish_test();
    end
endmodule : test_three_rail_alert_monitor
`default_nettype wire
